// ---- inc/sfr_link_if.sv ----
// Link between the host end and the flash read-path end.
// Assumes each line idles high through a pull-up when nobody drives it.
`timescale 1ns/1ps
interface sfr_link_if;
	logic       cs_n;
	logic       sclk;
	logic [3:0] host_out;
	logic [3:0] host_oe;
	logic [3:0] dev_out;
	logic [3:0] dev_oe;
	logic [3:0] io;

	// Resolve each line from the two enables, pull-up when idle
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			if (dev_oe[i])
				io[i] = dev_out[i];
			else if (host_oe[i])
				io[i] = host_out[i];
			else
				io[i] = 1'b1;
		end
	end

	modport host (output cs_n, output sclk, output host_out,
		output host_oe, input io);
	modport dev (input cs_n, input sclk, input io, output dev_out,
		output dev_oe);
endinterface

// ---- inc/sfr_pkg.sv ----
// Package for the serial flash read-path decoder and its host end.
// Assumes both ends run on one 200 MHz ref_clk; the link clock is
// made by the host end with a divider and sampled by the device end.
package sfr_pkg;

	// Read opcodes
	localparam logic [7:0] OP_READ     = 8'h03;
	localparam logic [7:0] OP_READ4    = 8'h13;
	localparam logic [7:0] OP_FAST     = 8'h0b;
	localparam logic [7:0] OP_FAST4    = 8'h0c;
	localparam logic [7:0] OP_DOUT     = 8'h3b;
	localparam logic [7:0] OP_DOUT4    = 8'h3c;
	localparam logic [7:0] OP_QOUT     = 8'h6b;
	localparam logic [7:0] OP_QOUT4    = 8'h6c;
	localparam logic [7:0] OP_DIO      = 8'hbb;

	// Phase lengths in link clocks and bits
	localparam logic [5:0] OPC_CLKS    = 6'h08;
	localparam logic [5:0] ADDR_W3     = 6'h18;
	localparam logic [5:0] ADDR_W4     = 6'h20;
	localparam logic [5:0] DUMMY_FAST  = 6'h08;
	localparam logic [5:0] DUMMY_DIO   = 6'h04;
	localparam logic [5:0] DUMMY_NONE  = 6'h00;
	localparam logic [3:0] BYTE_BITS   = 4'h8;
	localparam logic [7:0] MODE_BITS   = 8'hff;

	// Link clock made by the host end
	localparam int         CLK_PS      = 5000;
	localparam int         SCLK_HALF_PS = 80000;
	localparam logic [4:0] SCLK_HALF_CYC =
		5'((SCLK_HALF_PS + CLK_PS - 1) / CLK_PS);

	// Known read opcode
	function automatic logic sfr_known(input logic [7:0] op);
		case (op)
		OP_READ, OP_READ4, OP_FAST, OP_FAST4, OP_DOUT, OP_DOUT4,
		OP_QOUT, OP_QOUT4, OP_DIO: sfr_known = 1'b1;
		default: sfr_known = 1'b0;
		endcase
	endfunction

	// Opcode that always carries a 32-bit address
	function automatic logic sfr_force4(input logic [7:0] op);
		sfr_force4 = (op == OP_READ4) || (op == OP_FAST4) ||
			(op == OP_DOUT4) || (op == OP_QOUT4);
	endfunction

	// Opcode that needs the quad lines enabled
	function automatic logic sfr_quad(input logic [7:0] op);
		sfr_quad = (op == OP_QOUT) || (op == OP_QOUT4);
	endfunction

	// Lines used for the address
	function automatic logic [2:0] sfr_in_lanes(input logic [7:0] op);
		sfr_in_lanes = (op == OP_DIO) ? 3'h2 : 3'h1;
	endfunction

	// Lines used for the data
	function automatic logic [2:0] sfr_out_lanes(input logic [7:0] op);
		case (op)
		OP_DOUT, OP_DOUT4, OP_DIO: sfr_out_lanes = 3'h2;
		OP_QOUT, OP_QOUT4:         sfr_out_lanes = 3'h4;
		default:                   sfr_out_lanes = 3'h1;
		endcase
	endfunction

	// Dummy clocks after the address
	function automatic logic [5:0] sfr_dummy(input logic [7:0] op);
		case (op)
		OP_READ, OP_READ4: sfr_dummy = DUMMY_NONE;
		OP_DIO:            sfr_dummy = DUMMY_DIO;
		default:           sfr_dummy = DUMMY_FAST;
		endcase
	endfunction

	// Address clocks for a width and a lane count
	function automatic logic [5:0] sfr_addr_clks(input logic w32,
		input logic [2:0] lanes);
		logic [5:0] w;
		w = w32 ? ADDR_W4 : ADDR_W3;
		sfr_addr_clks = (lanes == 3'h2) ? (w >> 1) : w;
	endfunction

endpackage

// ---- test/sfr_link_sva.sv ----
// Checker for the flash read link: watches the interface lines only.
// Assumes the host end makes the link clock and chip select.
`timescale 1ns/1ps
module sfr_link_sva (
	// Clock and reset
	input wire logic       ref_clk,
	input wire logic       rst_b,
	// Link lines
	input wire logic       cs_n,
	input wire logic       sclk,
	input wire logic [3:0] host_out,
	input wire logic [3:0] host_oe,
	input wire logic [3:0] dev_out,
	input wire logic [3:0] dev_oe,
	input wire logic [3:0] io
);
	logic       sclk_q;
	logic [5:0] rise_q;

	// Count link clock rises within one frame
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			sclk_q <= 1'b0;
			rise_q <= 6'h00;
		end else begin
			sclk_q <= sclk;
			if (cs_n)
				rise_q <= 6'h00;
			else if (sclk && !sclk_q && rise_q != 6'h3f)
				rise_q <= rise_q + 6'h01;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	// Frame start and the quiet clock that must follow it
	sequence s_frame_open;
		$fell(cs_n);
	endsequence
	sequence s_clk_low_hold;
		!sclk [*8];
	endsequence
	property p_open_quiet;
		s_frame_open |-> s_clk_low_hold;
	endproperty

	a_frame_open_quiet: assert property (p_open_quiet)
		else $error("link clock moved right after chip select fell");
	a_opcode_drive: assert property (s_frame_open |-> host_oe[0] && dev_oe == 4'h0)
		else $error("opcode line not driven by host at frame start");
	a_no_contend: assert property ((host_oe & dev_oe) == 4'h0)
		else $error("host and device drive one line together");
	a_idle_clock_low: assert property (cs_n |-> !sclk)
		else $error("link clock high outside a frame");
	a_release_end: assert property (cs_n [*6] |-> dev_oe == 4'h0)
		else $error("device still drives after chip select rose");
	a_lines_idle: assert property (cs_n [*6] |-> io == 4'hf)
		else $error("a line still driven between frames");
	a_launch_fall: assert property ((dev_oe != 4'h0 && $past(dev_oe) != 4'h0
		&& dev_out != $past(dev_out)) |-> !sclk)
		else $error("device data changed while link clock high");
	a_host_hold_rise: assert property ($rose(sclk) |-> $stable(host_out)
		&& $stable(host_oe))
		else $error("host lines changed at a link clock rise");
	a_lane_groups: assert property (dev_oe != 4'h0 |->
		dev_oe inside {4'h2, 4'h3, 4'hf})
		else $error("device drives an illegal group of lines");
	a_quiet_header: assert property ((!cs_n && rise_q < 6'd24) |->
		dev_oe == 4'h0)
		else $error("device drove during opcode, address or dummies");
endmodule // sfr_link_sva

// ---- test/tb.sv ----
// Bench for the flash read link: host end and device end joined.
// Assumes a combinational array model and a 200 MHz ref_clk.
`timescale 1ns/1ps
module tb;
	logic        ref_clk, rst_b, clk_en, start, addr4, dev_busy, spi_std;
	logic        quad_lines_enable, host_busy, rx_valid, done, sclk_q;
	logic        read_active, cmd_refused;
	logic [7:0]  opcode, nbytes, ext_addr, mem_rdata, rx_data, mon_op;
	logic [7:0]  cur_op;
	logic [31:0] addr, mem_addr, mon_adr, seed, r;
	logic [3:0]  mon_d0;
	logic [7:0]  ops [9] = '{8'h03, 8'h13, 8'h0b, 8'h0c, 8'h3b, 8'h3c,
		8'h6b, 8'h6c, 8'hbb};
	int          bad_count, check_count, mon_n, a_clks, d_clks;

	sfr_link_if link ();
	sfr_host sfr_host_i (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en),
		.link(link), .start(start), .opcode(opcode), .addr(addr),
		.addr4(addr4), .nbytes(nbytes), .busy(host_busy),
		.rx_data(rx_data), .rx_valid(rx_valid), .done(done));
	sfr_dev sfr_dev_i (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en),
		.link(link), .busy(dev_busy), .spi_std(spi_std),
		.quad_lines_enable(quad_lines_enable),
		.address_width_state(addr4), .ext_addr(ext_addr),
		.mem_addr(mem_addr), .mem_rdata(mem_rdata),
		.read_active(read_active), .cmd_refused(cmd_refused));
	sfr_link_sva sfr_link_sva_i (.ref_clk(ref_clk), .rst_b(rst_b),
		.cs_n(link.cs_n), .sclk(link.sclk), .host_out(link.host_out),
		.host_oe(link.host_oe), .dev_out(link.dev_out),
		.dev_oe(link.dev_oe), .io(link.io));

	// Pseudo random source, fixed start
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Array contents as a function of the address
	function automatic logic [7:0] mem_fn(input logic [31:0] a);
		return (a[7:0] + {a[30:24], 1'b0} + a[23:16] + a[15:8]) ^ 8'h5a;
	endfunction
	// Array model: combinational read at the device's address
	assign mem_rdata = mem_fn(mem_addr);
	// Full 32-bit address expected on the wire
	function automatic logic w32(input logic [7:0] op, input logic m4);
		return m4 || op == 8'h13 || op[3:0] == 4'hc;
	endfunction
	function automatic int lanes_of(input logic [7:0] op);
		if (op == 8'h3b || op == 8'h3c || op == 8'hbb)
			return 2;
		return (op == 8'h6b || op == 8'h6c) ? 4 : 1;
	endfunction
	function automatic int dummy_of(input logic [7:0] op);
		if (op == 8'h03 || op == 8'h13)
			return 0;
		return (op == 8'hbb) ? 4 : 8;
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Follow the lines at each link clock rise, mid-cycle so all is settled
	always @(negedge ref_clk) begin
		if (link.cs_n !== 1'b0) begin
			mon_n = 0;
			mon_adr = 32'h0;
		end else if (link.sclk && !sclk_q) begin
			if (mon_n < 8)
				mon_op = {mon_op[6:0], link.io[0]};
			else if (mon_n < 8 + a_clks && cur_op == 8'hbb)
				mon_adr = {mon_adr[29:0], link.io[1:0]};
			else if (mon_n < 8 + a_clks)
				mon_adr = {mon_adr[30:0], link.io[0]};
			else if (mon_n == 8 + a_clks + d_clks)
				mon_d0 = link.io;
			mon_n++;
		end
		sclk_q = link.sclk;
	end

	// One read from start to done; called just after a rising edge
	task automatic do_read(input logic [7:0] op, input logic [31:0] a,
		input logic m4, input logic [7:0] n, input logic bz,
		input logic sp, input logic qen);
		logic [31:0] base;
		logic [7:0]  fb;
		logic        refuse, s_ref, s_act;
		int          k, lanes;
		refuse = bz || !sp || (!qen && (op == 8'h6b || op == 8'h6c));
		base = w32(op, m4) ? a : {~a[31:24], a[23:0]};
		fb = mem_fn(base);
		lanes = lanes_of(op);
		cur_op = op;
		a_clks = (w32(op, m4) ? 32 : 24) >> (op == 8'hbb);
		d_clks = dummy_of(op);
		s_ref = 1'b0;
		s_act = 1'b0;
		k = 0;
		dev_busy <= bz;
		spi_std <= sp;
		quad_lines_enable <= qen;
		addr4 <= m4;
		ext_addr <= ~a[31:24];
		start <= 1'b1;
		opcode <= op;
		addr <= a;
		nbytes <= n;
		@(posedge ref_clk);
		start <= 1'b0;
		for (int t = 0; t < 6000 && done !== 1'b1; t++) begin
			@(negedge ref_clk);
			s_ref |= (cmd_refused === 1'b1);
			s_act |= (read_active === 1'b1);
			if (t == 0)
				check(host_busy, 1'b1);
			if (rx_valid === 1'b1) begin
				check(rx_data, refuse ? 8'hff : mem_fn(base + k));
				k++;
			end
		end
		check(done, 1'b1);
		check(host_busy, 1'b0);
		check(k, n);
		check(mem_addr, refuse ? 32'h0 : base + n + 1);
		check(s_ref, refuse);
		check(s_act, !refuse);
		check(mon_op, op);
		check(mon_adr, w32(op, m4) ? a : {8'h00, a[23:0]});
		if (!refuse)
			check(lanes == 4 ? mon_d0 : lanes == 2 ? {2'h0, mon_d0[1:0]}
				: {3'h0, mon_d0[1]}, fb >> (8 - lanes));
		repeat (8) @(posedge ref_clk);
		$display("read %h with %0d bytes ended", op, n);
	endtask

	// Clock
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	// Hang guard
	initial begin
		#500000;
		bad_count++;
		test_done();
	end

	// Main sequence: corner cases first, then random reads
	initial begin
		{rst_b, start, addr4, dev_busy, quad_lines_enable} = 5'h0;
		{clk_en, spi_std} = 2'h3;
		{opcode, nbytes, ext_addr, addr} = 56'h0;
		{bad_count, check_count, mon_n, a_clks, d_clks} = '0;
		cur_op = 8'h0;
		sclk_q = 1'b0;
		seed = 32'd219;
		repeat (4) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		do_read(8'h13, 32'h89abcdef, 1'b0, 8'h2, 1'b0, 1'b1, 1'b1);
		do_read(8'h0b, 32'h12345678, 1'b1, 8'h1, 1'b0, 1'b1, 1'b1);
		do_read(8'h0c, 32'hffffffff, 1'b0, 8'h3, 1'b0, 1'b1, 1'b1);
		do_read(8'h6b, xs(), 1'b0, 8'h1, 1'b0, 1'b1, 1'b0);
		do_read(8'h13, xs(), 1'b0, 8'h1, 1'b1, 1'b1, 1'b1);
		do_read(8'h3c, xs(), 1'b0, 8'h1, 1'b0, 1'b0, 1'b1);
		do_read(8'hbb, 32'h00a5c3f0, 1'b1, 8'h2, 1'b0, 1'b1, 1'b1);
		for (int i = 0; i < 18; i++) begin
			r = xs();
			do_read(ops[i % 9], xs(), r[0], 8'(r[9:8]) + 8'h1,
				r[7:4] == 4'h0, r[15:12] != 4'h0, r[19:16] != 4'h0);
		end
		test_done();
	end
endmodule // tb

// ---- verilog/sfr_dev.sv ----
// Read-path decoder of a serial flash slave: takes the opcode, the
// address and the dummy clocks from the link and streams array data.
// Assumes the array answers mem_addr on mem_rdata within a few cycles
// and that the link clock is far slower than ref_clk.
//
// Operation
// R01: Opcode 13h always takes 32 address bits.
// R02: Reads ignored while busy; running cycle untouched.
// R03: 13h decoded only in standard single-line mode.
// R04: Fast read: eight dummy clocks, output undefined.
// R05: 0Ch: 32-bit address, single-line mode only.
// R06: 3Bh: two bits per clock on lines 0-1.
// R07: Host releases line zero before dual data.
// R08: 3Ch: 32-bit address, single-line mode only.
// R09: Quad output refused unless quad lines enabled.
// R10: 6Bh: four bits per clock after eight dummies.
// R11: Host releases all lines before quad data.
// R12: 6Ch: 32-bit address, single-line mode only.
// R13: BBh address two bits per clock, dual data.
// R14: BBh: four dummy clocks, inputs ignored.
// R15: Host sends mode bits with upper nibble ones.
// R16: Other reads: 32 bits in 4-byte mode, else 24.
// R17: 3-byte mode takes top byte from extension.
// R18: Address steps by one after each byte.
// R19: Capture on rising edge, launch on falling, MSB first.
// R20: Chip select high ends read, awaits opcode.
// R21: Highest line carries the most significant bit.
//
// Design decisions made here: the address map and the address-and-data array read port.
`timescale 1ns/1ps
module sfr_dev (
	// Clock, reset and freeze
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	input  wire logic        clk_en,
	// Link to the host
	sfr_link_if.dev          link,
	// Device state held elsewhere in the flash
	input  wire logic        busy,
	input  wire logic        spi_std,
	input  wire logic        quad_lines_enable,
	input  wire logic        address_width_state,
	input  wire logic [7:0]  ext_addr,
	// Array read port
	output logic      [31:0] mem_addr,
	input  wire logic [7:0]  mem_rdata,
	// Status
	output logic             read_active,
	output logic             cmd_refused
);

	typedef enum logic [2:0] {
		D_IDLE,
		D_OPC,
		D_ADR,
		D_DMY,
		D_DAT,
		D_IGN
	} sfr_dst_t;

	typedef struct packed {
		logic [5:0]  s1;       // {cs_n, sclk, io} first stage
		logic [5:0]  s2;       // second stage
		logic        sclk_p;   // Previous synced link clock
		sfr_dst_t    st;
		logic [7:0]  op;
		logic [5:0]  cnt;      // Clocks left in the phase
		logic        w32;      // Address is 32 bits wide
		logic [2:0]  lin;      // Address lanes
		logic [2:0]  lo;       // Data lanes
		logic [5:0]  dmy;      // Dummy clocks
		logic [31:0] addr;
		logic [7:0]  pre;      // Byte fetched at addr
		logic [7:0]  shift;    // Byte being sent
		logic [3:0]  left;     // Bits still to send
		logic [3:0]  io_out;
		logic [3:0]  io_oe;
		logic        active;
		logic        refused;
	} sfr_dev_t;

	sfr_dev_t q;
	sfr_dev_t d;

	// Outputs come straight from the state register
	assign link.dev_out = q.io_out;
	assign link.dev_oe  = q.io_oe;
	assign mem_addr     = q.addr;
	assign read_active  = q.active;
	assign cmd_refused  = q.refused;

	// Next state
	always_comb begin
		logic       rise;
		logic       fall;
		logic [3:0] din;
		logic [7:0] nop;
		logic [7:0] byte_v;
		logic [3:0] left_v;
		rise   = 1'b0;
		fall   = 1'b0;
		din    = 4'h0;
		nop    = 8'h00;
		byte_v = 8'h00;
		left_v = 4'h0;
		d      = q;
		// Pins pass two flip-flops before anything reads them
		d.s1     = {link.cs_n, link.sclk, link.io};
		d.s2     = q.s1;
		d.sclk_p = q.s2[4];
		d.pre    = mem_rdata;
		rise     = q.s2[4] & ~q.sclk_p;
		fall     = ~q.s2[4] & q.sclk_p;
		din      = q.s2[3:0];
		if (q.s2[5]) begin
			// Chip select high ends any read at once
			d.st      = D_IDLE;         // see R20
			d.io_oe   = 4'h0;           // see R20
			d.active  = 1'b0;
			d.refused = 1'b0;
			d.left    = 4'h0;
		end else begin
			case (q.st)
			D_IDLE: begin
				d.st   = D_OPC;
				d.cnt  = sfr_pkg::OPC_CLKS;
				d.op   = 8'h00;
				d.addr = 32'h0000_0000;
			end
			D_OPC: begin
				if (rise) begin
					// Opcode on line zero, MSB first
					nop   = {q.op[6:0], din[0]};     // see R19
					d.op  = nop;
					d.cnt = q.cnt - 6'h01;
					if (q.cnt == 6'h01) begin
						if (!sfr_pkg::sfr_known(nop) || !spi_std) begin
							d.st      = D_IGN;      // see R03 see R05
							d.refused = 1'b1;       // see R08 see R12
						end else if (busy) begin
							d.st      = D_IGN;      // see R02
							d.refused = 1'b1;
						end else if (sfr_pkg::sfr_quad(nop) &&
							!quad_lines_enable) begin
							d.st      = D_IGN;      // see R09
							d.refused = 1'b1;
						end else begin
							// Width fixed by opcode or by the mode
							d.w32 = sfr_pkg::sfr_force4(nop) ||
								address_width_state; // see R01 see R16
							d.lin = sfr_pkg::sfr_in_lanes(nop);
							d.lo  = sfr_pkg::sfr_out_lanes(nop);
							d.dmy = sfr_pkg::sfr_dummy(nop);
							d.cnt = sfr_pkg::sfr_addr_clks(d.w32, d.lin);
							d.st  = D_ADR;
							d.active = 1'b1;
						end
					end
				end
			end
			D_ADR: begin
				if (rise) begin
					// Dual address puts the MSB on line one
					if (q.lin == 3'h2)
						d.addr = {q.addr[29:0], din[1:0]}; // see R13 see R21
					else
						d.addr = {q.addr[30:0], din[0]};   // see R19
					d.cnt = q.cnt - 6'h01;
					if (q.cnt == 6'h01) begin
						if (!q.w32)
							d.addr[31:24] = ext_addr;      // see R17
						if (q.dmy != sfr_pkg::DUMMY_NONE) begin
							d.st  = D_DMY;
							d.cnt = q.dmy;                 // see R04 see R14
						end else begin
							d.st = D_DAT;
						end
					end
				end
			end
			D_DMY: begin
				// Inputs are not looked at, lines stay released
				if (rise) begin
					d.cnt = q.cnt - 6'h01;         // see R04 see R14
					if (q.cnt == 6'h01)
						d.st = D_DAT;
				end
			end
			D_DAT: begin
				if (fall) begin
					// Fetch the next byte once the last one is gone
					if (q.left == 4'h0) begin
						byte_v = q.pre;
						left_v = sfr_pkg::BYTE_BITS;
						d.addr = q.addr + 32'h0000_0001; // see R18
					end else begin
						byte_v = q.shift;
						left_v = q.left;
					end
					case (q.lo)
					3'h2: begin
						d.io_out = {2'b00, byte_v[7:6]};  // see R06 see R13
						d.io_oe  = 4'h3;                  // see R21
					end
					3'h4: begin
						d.io_out = byte_v[7:4];           // see R10 see R21
						d.io_oe  = 4'hf;
					end
					default: begin
						d.io_out = {2'b00, byte_v[7], 1'b0}; // see R19
						d.io_oe  = 4'h2;
					end
					endcase
					d.shift = byte_v << q.lo;
					d.left  = left_v - {1'b0, q.lo};
				end
			end
			D_IGN: begin
				// Wait for chip select; nothing is driven
				d.io_oe = 4'h0;                       // see R02
			end
			default: begin
				d.st = D_IDLE;
			end
			endcase
		end
	end

	// State register, frozen while clk_en is low
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			q    <= '0;
			q.s1 <= 6'h3f;
			q.s2 <= 6'h3f;
			q.st <= D_IDLE;
		end else if (clk_en) begin
			q <= d;
		end
	end

endmodule // sfr_dev

// ---- verilog/sfr_host.sv ----
// Host end of the flash read link: makes the link clock and chip
// select, sends opcode, address and mode bits, and collects data.
// Assumes a user that raises start for one cycle while busy is low.
`timescale 1ns/1ps
module sfr_host (
	// Clock, reset and freeze
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	input  wire logic        clk_en,
	// Link to the device
	sfr_link_if.host         link,
	// Read request
	input  wire logic        start,
	input  wire logic [7:0]  opcode,
	input  wire logic [31:0] addr,
	input  wire logic        addr4,
	input  wire logic [7:0]  nbytes,
	// Read answer
	output logic             busy,
	output logic      [7:0]  rx_data,
	output logic             rx_valid,
	output logic             done
);

	typedef enum logic [1:0] {H_IDLE, H_RUN, H_END} sfr_hst_t;
	typedef enum logic [1:0] {P_OPC, P_ADR, P_DMY, P_DAT} sfr_hph_t;

	typedef struct packed {
		logic [3:0]  s1;
		logic [3:0]  s2;
		sfr_hst_t    st;
		sfr_hph_t    ph;
		logic [4:0]  div;
		logic        sclk;
		logic        cs_n;
		logic [39:0] sh;       // Opcode and address, MSB first
		logic [10:0] cnt;
		logic [5:0]  acnt;
		logic [5:0]  dmy;
		logic [10:0] ndat;
		logic [2:0]  lin;
		logic [2:0]  lo;
		logic [3:0]  io_out;
		logic [3:0]  io_oe;
		logic [7:0]  rx;
		logic [3:0]  rxn;
		logic [7:0]  rdat;
		logic        rxv;
		logic        done;
		logic        busy;
	} sfr_host_t;

	sfr_host_t q;
	sfr_host_t d;

	// Outputs come straight from the state register
	assign link.cs_n     = q.cs_n;
	assign link.sclk     = q.sclk;
	assign link.host_out = q.io_out;
	assign link.host_oe  = q.io_oe;
	assign busy          = q.busy;
	assign rx_data       = q.rdat;
	assign rx_valid      = q.rxv;
	assign done          = q.done;

	// Next state
	always_comb begin
		logic       tick;
		logic       w32;
		logic [7:0] nrx;
		tick = 1'b0;
		w32  = 1'b0;
		nrx  = 8'h00;
		d    = q;
		d.s1   = link.io;
		d.s2   = q.s1;
		d.rxv  = 1'b0;
		d.done = 1'b0;
		tick   = (q.div == sfr_pkg::SCLK_HALF_CYC - 5'h01);
		case (q.st)
		H_IDLE: begin
			if (start) begin
				w32    = sfr_pkg::sfr_force4(opcode) || addr4; // see R16
				d.sh   = w32 ? {opcode, addr} : {opcode, addr[23:0], 8'h00};
				d.lin  = sfr_pkg::sfr_in_lanes(opcode);
				d.lo   = sfr_pkg::sfr_out_lanes(opcode);
				d.dmy  = sfr_pkg::sfr_dummy(opcode);
				d.acnt = sfr_pkg::sfr_addr_clks(w32, d.lin);
				d.ndat = {nbytes, 3'b000} >> (d.lo >> 1);
				d.cnt  = {5'h00, sfr_pkg::OPC_CLKS};
				d.ph   = P_OPC;
				d.cs_n = 1'b0;
				d.sclk = 1'b0;
				d.div  = 5'h00;
				d.rxn  = 4'h0;
				d.io_out = {3'b000, opcode[7]};   // see R03
				d.io_oe  = 4'h1;
				d.busy = 1'b1;
				d.st   = H_RUN;
			end
		end
		H_RUN: begin
			d.div = tick ? 5'h00 : q.div + 5'h01;
			if (tick && !q.sclk) begin
				// Rising edge: sample data, advance the phase
				d.sclk = 1'b1;
				if (q.ph == P_DAT) begin
					case (q.lo)
					3'h2:    nrx = {q.rx[5:0], q.s2[1:0]};  // see R21
					3'h4:    nrx = {q.rx[3:0], q.s2};
					default: nrx = {q.rx[6:0], q.s2[1]};
					endcase
					d.rx  = nrx;
					d.rxn = q.rxn + {1'b0, q.lo};
					if (d.rxn == sfr_pkg::BYTE_BITS) begin
						d.rxn  = 4'h0;
						d.rdat = nrx;
						d.rxv  = 1'b1;
					end
				end
				if (q.ph == P_ADR && q.lin == 3'h2)
					d.sh = q.sh << 2;
				else
					d.sh = q.sh << 1;
				d.cnt = q.cnt - 11'h001;
				if (q.cnt == 11'h001) begin
					case (q.ph)
					P_OPC: begin
						d.ph  = P_ADR;
						d.cnt = {5'h00, q.acnt};
					end
					P_ADR: begin
						if (q.dmy != sfr_pkg::DUMMY_NONE) begin
							d.ph  = P_DMY;
							d.cnt = {5'h00, q.dmy};
						end else begin
							d.ph  = P_DAT;
							d.cnt = q.ndat;
						end
					end
					P_DMY: begin
						d.ph  = P_DAT;
						d.cnt = q.ndat;
					end
					default: d.st = H_END;
					endcase
				end
			end else if (tick) begin
				// Falling edge: present the bits of the next clock
				d.sclk = 1'b0;
				case (q.ph)
				P_OPC: begin
					d.io_out = {3'b000, q.sh[39]};
					d.io_oe  = 4'h1;
				end
				P_ADR: begin
					if (q.lin == 3'h2) begin
						d.io_out = {2'b00, q.sh[39:38]};  // see R13 see R21
						d.io_oe  = 4'h3;
					end else begin
						d.io_out = {3'b000, q.sh[39]};
						d.io_oe  = 4'h1;
					end
				end
				P_DMY: begin
					if (q.lin == 3'h2) begin
						d.io_out = {2'b00, sfr_pkg::MODE_BITS[1:0]}; // see R15
						d.io_oe  = 4'h3;
					end else begin
						d.io_oe  = 4'h0;                 // see R07 see R11
					end
				end
				default: d.io_oe = 4'h0;               // see R07 see R11
				endcase
			end
		end
		H_END: begin
			// Drop the clock, then raise chip select
			d.div = tick ? 5'h00 : q.div + 5'h01;
			if (tick) begin
				if (q.sclk) begin
					d.sclk = 1'b0;
				end else begin
					d.cs_n = 1'b1;                     // see R20
					d.busy = 1'b0;
					d.done = 1'b1;
					d.st   = H_IDLE;
				end
			end
		end
		default: d.st = H_IDLE;
		endcase
	end

	// State register, frozen while clk_en is low
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			q      <= '0;
			q.cs_n <= 1'b1;
			q.s1   <= 4'hf;
			q.s2   <= 4'hf;
			q.st   <= H_IDLE;
			q.ph   <= P_OPC;
		end else if (clk_en) begin
			q <= d;
		end
	end

endmodule // sfr_host
